// [rtl/adcgc_ctrl.sv]
// serial control, gain calibration and result path of the converter
// What this block does
// - 24-bit gain in three bytes 08h..0Ah, low first; resets 00h,00h,40h.
// - pin control mode ignores registers; register mode uses them.
// - registers written one at a time or as a block.
// - written registers can be read back by the host.
// - host picks continuous or by-command read mode after setup.
// - conversions run freely while the sync input is high.
// - sync low halts conversions; return high restarts them.
// - continuous mode: result shifts out on sclk after ready falls.
// - by-command mode: ready asserts only after a read-data command.
// - synchronised parts may share one ready line for timing.
// - a modulator over-range flag output is provided.
// - first two filter sections scale by 2^23, centre tap 4194304.
// - sections three, four: phase selects linear or minimum set.
module adcgc_ctrl (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // serial link
  input  wire logic                  sclk,
  input  wire logic                  din,
  output logic                       dout,
  // control pins
  input  wire logic                  sync_in,
  input  wire logic                  pin_ctrl,
  input  wire logic                  pin_phase,
  output logic                       result_ready_n,
  output logic                       over_range_flag,
  // filter side
  input  wire adcgc_pkg::adcgc_conv_t conv,
  output logic                       conv_run,
  output logic                       fir_min_phase
);

  adcgc_pkg::adcgc_state_t s;
  adcgc_pkg::adcgc_state_t next_s;

  logic               sclk_s;
  logic               din_s;
  logic               rise;
  logic               fall;
  logic               byte_end;
  logic [7:0]         byte_now;
  logic               cmd_rdata;
  logic [23:0]        geff;
  logic signed [48:0] prod;
  logic [23:0]        corr;
  logic [7:0]         rd_byte;

  function automatic logic [7:0] reg_rd(input logic [4:0]  a,
                                        input logic [7:0]  c,
                                        input logic [23:0] g);
    case (a)
      adcgc_pkg::ADDR_CFG:     reg_rd = c;
      adcgc_pkg::ADDR_GAIN_LO: reg_rd = g[7:0];
      adcgc_pkg::ADDR_GAIN_MD: reg_rd = g[15:8];
      adcgc_pkg::ADDR_GAIN_HI: reg_rd = g[23:16];
      default:                 reg_rd = 8'h00;
    endcase
  endfunction

  assign sclk_s   = s.sclk_ff[1];
  assign din_s    = s.din_ff[1];
  assign rise     = sclk_s & ~s.sclk_d;
  assign fall     = ~sclk_s & s.sclk_d;
  assign byte_end = rise && (s.bitcnt == 3'h7);
  assign byte_now = {s.sh_in[6:0], din_s};
  assign cmd_rdata = byte_end && (s.st == adcgc_pkg::ST_CMD) && !s.rdc
                     && (byte_now == adcgc_pkg::CMD_RDATA);
  // pin mode runs on the reset gain
  assign geff = s.mode_ff[1] ? {adcgc_pkg::GAIN_HI_RESET,
                                adcgc_pkg::GAIN_MD_RESET,
                                adcgc_pkg::GAIN_LO_RESET} : s.gain;
  assign prod = $signed(conv.data) * $signed({1'b0, geff});
  assign corr = prod[adcgc_pkg::GAIN_SHIFT+23:adcgc_pkg::GAIN_SHIFT];
  assign rd_byte = reg_rd(s.addr, s.cfg, s.gain);

  always_comb begin
    next_s = s;
    next_s.sclk_ff  = {s.sclk_ff[0], sclk};
    next_s.sclk_d   = s.sclk_ff[1];
    next_s.din_ff   = {s.din_ff[0], din};
    next_s.sync_ff  = {s.sync_ff[0], sync_in};
    next_s.mode_ff  = {s.mode_ff[0], pin_ctrl};
    next_s.phase_ff = {s.phase_ff[0], pin_phase};
    next_s.over     = conv.over_range;
    next_s.minph    = s.mode_ff[1] ? s.phase_ff[1]
                      : s.cfg[adcgc_pkg::CFG_PHASE_BIT];
    next_s.run      = s.sync_ff[1];
    // shift out on falling sclk, except right after a byte-end load
    if (fall) begin
      if (s.hold) begin
        next_s.hold = 1'b0;
      end else begin
        next_s.sh_out = {s.sh_out[22:0], 1'b0};
      end
    end
    if (rise) begin
      next_s.sh_in   = byte_now;
      next_s.bitcnt  = s.bitcnt + 3'h1;
      next_s.rec_cnt = 7'h00;
      next_s.result_ready_n_n  = 1'b1;
    end
    if (byte_end) begin
      case (s.st)
        adcgc_pkg::ST_CMD: begin
          if (s.rdc) begin
            if (byte_now == adcgc_pkg::CMD_SDATAC) begin
              next_s.rdc = 1'b0;
            end
          end else if (byte_now == adcgc_pkg::CMD_RDATAC) begin
            next_s.rdc = 1'b1;
          end else if (byte_now == adcgc_pkg::CMD_RDATA) begin
            next_s.sh_out = s.result;
            next_s.hold   = 1'b1;
            next_s.result_ready_n_n = 1'b0;
          end else if (byte_now[7:5] == adcgc_pkg::CMD_RREG ||
                       byte_now[7:5] == adcgc_pkg::CMD_WREG) begin
            next_s.addr = byte_now[4:0];
            next_s.wr   = (byte_now[7:5] == adcgc_pkg::CMD_WREG);
            next_s.st   = adcgc_pkg::ST_ARG;
          end
        end
        adcgc_pkg::ST_ARG: begin
          next_s.cnt = byte_now[4:0];
          if (s.wr) begin
            next_s.st = adcgc_pkg::ST_WR;
          end else begin
            next_s.st     = adcgc_pkg::ST_RD;
            next_s.sh_out = {rd_byte, 16'h0000};
            next_s.hold   = 1'b1;
          end
        end
        adcgc_pkg::ST_WR: begin
          if (!s.mode_ff[1]) begin
            case (s.addr)
              adcgc_pkg::ADDR_CFG:     next_s.cfg = byte_now;
              adcgc_pkg::ADDR_GAIN_LO: next_s.gain[7:0] = byte_now;
              adcgc_pkg::ADDR_GAIN_MD: next_s.gain[15:8] = byte_now;
              adcgc_pkg::ADDR_GAIN_HI: next_s.gain[23:16] = byte_now;
              default:                 next_s.cfg = s.cfg;
            endcase
          end
          next_s.addr = s.addr + 5'h01;
          if (s.cnt == 5'h00) begin
            next_s.st = adcgc_pkg::ST_CMD;
          end else begin
            next_s.cnt = s.cnt - 5'h01;
          end
        end
        adcgc_pkg::ST_RD: begin
          next_s.addr = s.addr + 5'h01;
          if (s.cnt == 5'h00) begin
            next_s.st = adcgc_pkg::ST_CMD;
          end else begin
            next_s.cnt    = s.cnt - 5'h01;
            next_s.sh_out = {reg_rd(s.addr + 5'h01, s.cfg, s.gain),
                             16'h0000};
            next_s.hold   = 1'b1;
          end
        end
        default: begin
          next_s.st = adcgc_pkg::ST_CMD;
        end
      endcase
    end
    if (conv.valid && s.run) begin
      next_s.result = corr;
      if (s.rdc) begin
        next_s.sh_out = corr;
        next_s.hold   = 1'b0;
        next_s.result_ready_n_n = 1'b0;
        if (!sclk_s) begin
          next_s.rec_cnt = s.rec_cnt + 7'h01;
          if (s.rec_cnt + 7'h01 == adcgc_pkg::RECOVER_PERIODS) begin
            next_s.bitcnt  = 3'h0;
            next_s.st      = adcgc_pkg::ST_CMD;
            next_s.rec_cnt = 7'h00;
          end
        end
      end
    end
    if (!s.sync_ff[1]) begin
      next_s.result_ready_n_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s        <= '0;
      s.cfg    <= adcgc_pkg::CFG_RESET;
      s.gain   <= {adcgc_pkg::GAIN_HI_RESET, adcgc_pkg::GAIN_MD_RESET,
                   adcgc_pkg::GAIN_LO_RESET};
      s.result_ready_n_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign dout            = s.sh_out[23];
  assign result_ready_n  = s.result_ready_n_n;
  assign over_range_flag = s.over;
  assign conv_run        = s.run;
  assign fir_min_phase   = s.minph;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sync_low_s;
    !s.sync_ff[1];
  endsequence

  sequence halted_s;
    !s.run && s.result_ready_n_n;
  endsequence

  gain_reset_a: assert property (disable iff (1'b0)
    rst |=> s.gain == 24'h400000)
    else $error("gain value wrong after reset");

  pin_mode_a: assert property (
    s.mode_ff[1] |=> s.gain == $past(s.gain))
    else $error("register written in pin mode");

  block_write_a: assert property (
    (s.st == adcgc_pkg::ST_WR && byte_end && s.cnt != 5'h00)
    |=> s.st == adcgc_pkg::ST_WR && s.addr == $past(s.addr) + 5'h01)
    else $error("block write did not advance");

  read_back_a: assert property (
    (s.st == adcgc_pkg::ST_ARG && byte_end && !s.wr)
    |=> s.sh_out[23:16] == $past(rd_byte) && s.hold)
    else $error("read-back byte not loaded");

  sync_halt_a: assert property (sync_low_s |=> halted_s)
    else $error("conversions not halted by sync low");

  sync_run_a: assert property (s.sync_ff[1] |=> s.run)
    else $error("conversions not running with sync high");

  cont_present_a: assert property (
    (s.rdc && s.run && conv.valid && s.sync_ff[1])
    |=> !result_ready_n && s.sh_out == $past(corr))
    else $error("continuous result not presented");

  cmd_ready_a: assert property (
    (!s.rdc && s.result_ready_n_n && !cmd_rdata) |=> s.result_ready_n_n)
    else $error("ready asserted without read command");

  over_range_a: assert property (
    ##1 over_range_flag == $past(conv.over_range))
    else $error("over-range flag not following modulator");

  phase_sel_a: assert property (
    !s.mode_ff[1] |=> fir_min_phase == $past(s.cfg[2]))
    else $error("phase select not from register");

  // last quiet ready period before the link is recovered
  sequence last_quiet_s;
    s.rdc && s.run && conv.valid && !sclk_s
    && s.rec_cnt == adcgc_pkg::RECOVER_PERIODS - 7'h01;
  endsequence

  sequence link_reset_s;
    s.bitcnt == 3'h0 && s.rec_cnt == 7'h00 && s.st == adcgc_pkg::ST_CMD;
  endsequence

  link_recover_a: assert property (last_quiet_s |=> link_reset_s)
    else $error("link not recovered after quiet periods");

  unity_gain_a: assert property (
    (conv.valid && geff == adcgc_pkg::FIR12_CENTRE) |-> corr == conv.data)
    else $error("centre-tap gain does not pass data through");

  rdata_load_a: assert property (
    (cmd_rdata && s.sync_ff[1])
    |=> !s.result_ready_n_n && s.hold && s.sh_out == $past(s.result))
    else $error("read command did not present the result");

  cont_enter_a: assert property (
    (byte_end && s.st == adcgc_pkg::ST_CMD && !s.rdc
     && byte_now == adcgc_pkg::CMD_RDATAC) |=> s.rdc)
    else $error("continuous mode not entered");

  cont_leave_a: assert property (
    (byte_end && s.rdc && byte_now == adcgc_pkg::CMD_SDATAC) |=> !s.rdc)
    else $error("continuous mode not left");

  cont_refuse_a: assert property (
    (byte_end && s.rdc && byte_now != adcgc_pkg::CMD_SDATAC)
    |=> s.rdc && s.st == adcgc_pkg::ST_CMD)
    else $error("byte taken in continuous mode");

  write_lands_a: assert property (
    (s.st == adcgc_pkg::ST_WR && byte_end && !s.mode_ff[1]
     && s.addr == adcgc_pkg::ADDR_GAIN_HI)
    |=> s.gain[23:16] == $past(byte_now))
    else $error("gain high byte write lost");

  read_end_a: assert property (
    (s.st == adcgc_pkg::ST_RD && byte_end && s.cnt == 5'h00)
    |=> s.st == adcgc_pkg::ST_CMD)
    else $error("register read did not end");

endmodule

// [rtl/adcgc_pkg.sv]
// shared constants and types of the gain-calibration control block
package adcgc_pkg;
  // register addresses
  localparam logic [4:0] ADDR_CFG     = 5'h01;
  localparam logic [4:0] ADDR_GAIN_LO = 5'h08;
  localparam logic [4:0] ADDR_GAIN_MD = 5'h09;
  localparam logic [4:0] ADDR_GAIN_HI = 5'h0A;
  // reset values
  localparam logic [7:0] CFG_RESET     = 8'h52;
  localparam logic [7:0] GAIN_LO_RESET = 8'h00;
  localparam logic [7:0] GAIN_MD_RESET = 8'h00;
  localparam logic [7:0] GAIN_HI_RESET = 8'h40;
  localparam int         CFG_PHASE_BIT = 2;
  // command bytes; register commands carry the address in bits 4:0
  localparam logic [7:0] CMD_RDATAC = 8'h10;
  localparam logic [7:0] CMD_SDATAC = 8'h11;
  localparam logic [7:0] CMD_RDATA  = 8'h12;
  localparam logic [2:0] CMD_RREG   = 3'h1;
  localparam logic [2:0] CMD_WREG   = 3'h2;
  // interface recovery: ready periods with the serial clock held low
  localparam logic [6:0] RECOVER_PERIODS = 7'h40;
  // filter coefficient scaling, both as powers of two
  localparam int          FIR12_SCALE_LOG2 = 23;
  localparam logic [23:0] FIR12_CENTRE     = 24'h400000;
  localparam int          FIR34_SCALE_LOG2 = 27;
  // gain unity equals the centre tap, so the product drops 22 bits
  localparam int          GAIN_SHIFT       = FIR12_SCALE_LOG2 - 1;

  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_ARG = 2'b01,
    ST_WR  = 2'b10,
    ST_RD  = 2'b11
  } adcgc_st_t;

  typedef struct packed {
    logic        valid;
    logic        over_range;
    logic [23:0] data;
  } adcgc_conv_t;

  typedef struct packed {
    logic [1:0]  sclk_ff;
    logic        sclk_d;
    logic [1:0]  din_ff;
    logic [1:0]  sync_ff;
    logic [1:0]  mode_ff;
    logic [1:0]  phase_ff;
    adcgc_st_t   st;
    logic        rdc;
    logic        wr;
    logic [2:0]  bitcnt;
    logic [7:0]  sh_in;
    logic [23:0] sh_out;
    logic        hold;
    logic [4:0]  addr;
    logic [4:0]  cnt;
    logic [7:0]  cfg;
    logic [23:0] gain;
    logic [23:0] result;
    logic        result_ready_n_n;
    logic [6:0]  rec_cnt;
    logic        over;
    logic        run;
    logic        minph;
  } adcgc_state_t;
endpackage

// [verif/adcgc_host.sv]
// host side model of the serial link, clocked from the converter clock
module adcgc_host (
  // clock
  input  wire logic clk,
  // serial link
  input  wire logic dout,
  output logic      sclk,
  output logic      din
);
  timeunit 1ns;
  timeprecision 1ns;

  // shared clock source, 8 clk per serial bit
  initial begin
    sclk = 1'b0;
    din  = 1'b0;
  end

  // one byte, msb first; sample dout just before each rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      din = tx[i];
      repeat (4) @(negedge clk);
      rx[i] = dout;
      sclk = 1'b1;
      // flip data while high: the bit must already be taken at the rise
      repeat (2) @(negedge clk);
      din = ~tx[i];
      repeat (2) @(negedge clk);
      sclk = 1'b0;
    end
  endtask

  // stray clock pulses that leave the byte counter misaligned
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
  endtask

  task automatic send(input logic [7:0] b);
    logic [7:0] r;
    xfer(b, r);
  endtask

  // leave continuous mode before register access
  task automatic stop_cont();
    send(adcgc_pkg::CMD_SDATAC);
  endtask

  // 24-bit result, msb first, no command needed
  task automatic read24(output logic [23:0] v);
    for (int k = 2; k >= 0; k--) begin
      xfer(8'h00, v[8*k +: 8]);
    end
  endtask
endmodule

// [verif/tb.sv]
// self-checking bench of the gain-calibration control block
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic                   clk;
  logic                   rst;
  logic                   sclk;
  logic                   din;
  logic                   dout;
  logic                   sync_in;
  logic                   pin_ctrl;
  logic                   pin_phase;
  logic                   result_ready_n;
  logic                   over_range_flag;
  adcgc_pkg::adcgc_conv_t conv;
  logic                   conv_run;
  logic                   fir_min_phase;
  logic [23:0]            v;
  int                     errors;
  int                     compares;

  adcgc_ctrl adcgc_ctrl_i (.clk(clk), .rst(rst), .sclk(sclk), .din(din),
    .dout(dout), .sync_in(sync_in), .pin_ctrl(pin_ctrl),
    .pin_phase(pin_phase), .result_ready_n(result_ready_n),
    .over_range_flag(over_range_flag), .conv(conv), .conv_run(conv_run),
    .fir_min_phase(fir_min_phase));

  adcgc_host adcgc_host_i (.clk(clk), .dout(dout), .sclk(sclk), .din(din));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_sim();
    $display("counts: compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input int n, input logic [23:0] d);
    adcgc_host_i.send({adcgc_pkg::CMD_WREG, a});
    adcgc_host_i.send(8'(n));
    for (int k = 0; k <= n; k++) begin
      adcgc_host_i.send(d[8*k +: 8]);
    end
  endtask

  task automatic rd3(input logic [4:0] a, output logic [23:0] d);
    adcgc_host_i.send({adcgc_pkg::CMD_RREG, a});
    adcgc_host_i.send(8'h02);
    for (int k = 0; k < 3; k++) begin
      adcgc_host_i.xfer(8'h00, d[8*k +: 8]);
    end
  endtask

  task automatic pulse(input logic [23:0] d);
    @(negedge clk);
    conv = '{valid: 1'b1, over_range: 1'b0, data: d};
    @(negedge clk);
    conv.valid = 1'b0;
  endtask

  task automatic t_regs();
    adcgc_host_i.stop_cont();
    rd3(adcgc_pkg::ADDR_GAIN_LO, v);
    chk(v, 24'h400000, "gain reset");
    rd3(5'h1D, v);
    chk(v, 24'h000000, "unmapped read");
    wr(adcgc_pkg::ADDR_GAIN_LO, 2, 24'h200000);
    rd3(adcgc_pkg::ADDR_GAIN_LO, v);
    chk(v, 24'h200000, "gain readback");
    $display("test regs done");
  endtask

  task automatic t_cmd_read();
    pulse(24'h123456);
    repeat (6) @(negedge clk);
    chk(24'(result_ready_n), 24'h1, "ready before cmd");
    adcgc_host_i.send(adcgc_pkg::CMD_RDATA);
    chk(24'(result_ready_n), 24'h0, "ready after cmd");
    adcgc_host_i.read24(v);
    chk(v, 24'h091A2B, "scaled result");
    chk(24'(result_ready_n), 24'h1, "ready after read");
    $display("test cmd_read done");
  endtask

  task automatic t_cont_read();
    adcgc_host_i.send(adcgc_pkg::CMD_RDATAC);
    // let the last falling edge clear the synchroniser first
    repeat (4) @(negedge clk);
    pulse(24'h2468AC);
    @(negedge clk);
    chk(24'(result_ready_n), 24'h0, "ready cont");
    adcgc_host_i.read24(v);
    chk(v, 24'h123456, "cont result");
    chk(24'(result_ready_n), 24'h1, "ready cont end");
    adcgc_host_i.stop_cont();
    $display("test cont_read done");
  endtask

  task automatic t_recover();
    adcgc_host_i.send(adcgc_pkg::CMD_RDATAC);
    adcgc_host_i.stray(3);
    repeat (4) @(negedge clk);
    for (int k = 0; k < adcgc_pkg::RECOVER_PERIODS; k++) begin
      pulse(24'h000010);
    end
    adcgc_host_i.stop_cont();
    rd3(adcgc_pkg::ADDR_GAIN_LO, v);
    chk(v, 24'h200000, "link recovered");
    $display("test recover done");
  endtask

  task automatic t_sync();
    sync_in = 1'b0;
    repeat (5) @(negedge clk);
    chk(24'(conv_run), 24'h0, "halted");
    pulse(24'h000100);
    adcgc_host_i.send(adcgc_pkg::CMD_RDATA);
    chk(24'(result_ready_n), 24'h1, "no ready halted");
    sync_in = 1'b1;
    repeat (5) @(negedge clk);
    chk(24'(conv_run), 24'h1, "running");
    $display("test sync done");
  endtask

  task automatic t_flag_pins();
    @(negedge clk);
    conv.over_range = 1'b1;
    @(negedge clk);
    chk(24'(over_range_flag), 24'h1, "flag set");
    conv.over_range = 1'b0;
    @(negedge clk);
    chk(24'(over_range_flag), 24'h0, "flag clear");
    pin_ctrl = 1'b1;
    pin_phase = 1'b1;
    repeat (5) @(negedge clk);
    chk(24'(fir_min_phase), 24'h1, "pin phase");
    pulse(24'h654321);
    adcgc_host_i.send(adcgc_pkg::CMD_RDATA);
    adcgc_host_i.read24(v);
    chk(v, 24'h654321, "pin mode unity gain");
    wr(adcgc_pkg::ADDR_CFG, 0, 24'h000056);
    pin_ctrl = 1'b0;
    repeat (5) @(negedge clk);
    chk(24'(fir_min_phase), 24'h0, "pin write ignored");
    wr(adcgc_pkg::ADDR_CFG, 0, 24'h000056);
    repeat (5) @(negedge clk);
    chk(24'(fir_min_phase), 24'h1, "reg phase");
    $display("test flag_pins done");
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("unexpected at %0t: timeout", $time);
    end_sim();
  end

  initial begin
    errors = 0;
    compares = 0;
    rst = 1'b1;
    sync_in = 1'b1;
    pin_ctrl = 1'b0;
    pin_phase = 1'b0;
    conv = '0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_cmd_read();
    t_cont_read();
    t_recover();
    t_sync();
    t_flag_pins();
    end_sim();
  end
endmodule
